// File: cpu_model.sv
// Bus master model of the CPU that reaches the timer core registers.
// Assumes one clk_sys; it changes strobes only right after rising edges.
`timescale 1ns/1ps

module cpu_model
	import timer_pkg::*;
(
	input  wire logic       clk_sys,
	output logic      [3:0] addr,
	output logic      [7:0] wdata,
	output logic            wr_stb,
	output logic            rd_stb,
	input  wire logic [7:0] rdata
);
	// ==========================================================
	// Idle bus
	// Quiet bus from time zero
	initial begin
		addr   = 4'h0;
		wdata  = 8'h00;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	end

	// ==========================================================
	// Bus cycles
	// One-cycle write, slave never stalls
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		addr   <= a;
		wdata  <= v;
		wr_stb <= 1'b1;
		@(posedge clk_sys);
		wr_stb <= 1'b0;
	endtask

	// One-cycle read, data taken in the next cycle only
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge clk_sys);
		rd_stb <= 1'b0;
		@(posedge clk_sys);
		v = rdata;
	endtask
endmodule

// File: testbench.sv
// Self-checking bench for the timer core with random and corner stimulus.
// Assumes the cpu_model bus master; the bench drives both channel pins.
`timescale 1ns/1ps

module testbench
	import timer_pkg::*;
;
	localparam logic [3:0] A_SC  = ADDR_STATUS_CONTROL;
	localparam logic [3:0] A_CH  = ADDR_COUNTER_HIGH;
	localparam logic [3:0] A_CL  = ADDR_COUNTER_LOW;
	localparam logic [3:0] A_PH  = ADDR_PERIOD_HIGH;
	localparam logic [3:0] A_PL  = ADDR_PERIOD_LOW;
	logic        clk_sys, resetn, wr_stb, rd_stb, brk, bce, wait_mode, ext_clk, ch1_in, ch0_in;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata, d;
	logic        force_in, ch0_out, ch0_oe, ovf_irq, ch1_irq, wake, ch0_irq, ch1_out, ch1_oe;
	logic [15:0] cnt, exp16;
	logic [7:0]  ctl [5] = '{8'h18, 8'h1A, 8'h1A, 8'h1B, 8'h2B};
	logic [7:0]  cmp [5] = '{8'h08, 8'h08, 8'h0F, 8'h08, 8'h08};
	int          hi  [5] = '{0, 36, 32, 64, 64};
	int          errors = 0, samples_checked = 0, cycles = 0, i, j, n;

`define CHK(nm, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
	$display("BAD %s exp %0h got %0h", nm, e, s); end end

	cpu_model u_cpu_model (.clk_sys(clk_sys), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
		.rd_stb(rd_stb), .rdata(rdata));
	timer_core u_timer_core (.clk_sys(clk_sys), .resetn(resetn), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .break_active(brk),
		.break_clear_enable(bce), .wait_mode(wait_mode), .external_timer_clock_pin(ext_clk),
		.external_clock_force_input(force_in), .channel0_pin_in(ch0_in),
		.channel0_pin_out(ch0_out), .channel0_pin_oe(ch0_oe), .channel1_pin_in(ch1_in),
		.channel1_pin_out(ch1_out), .channel1_pin_oe(ch1_oe), .overflow_irq(ovf_irq),
		.channel0_irq(ch0_irq), .channel1_irq(ch1_irq), .wake_request(wake));

	// ==========================================================
	// Clock, timeout, helpers
	initial begin
		clk_sys = 1'b0;
		forever #(CLK_PERIOD_NS / 2) clk_sys = ~clk_sys;
	end

	// Hang guard
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			end_of_test();
		end
	end

	// Expected count after a run at a given divider
	function automatic logic [15:0] presc_exp(input int cyc, input int ps);
		return 16'(cyc >> ps);
	endfunction

	task automatic w(input logic [3:0] a, input logic [7:0] v);
		u_cpu_model.wr(a, v);
	endtask
	task automatic r(input logic [3:0] a);
		u_cpu_model.rd(a, d);
	endtask
	// Counter read, high byte first
	task automatic rc;
		r(A_CH);
		cnt[15:8] = d;
		r(A_CL);
		cnt[7:0] = d;
	endtask
	task automatic near(input string nm, input logic [15:0] e, input int tol);
		`CHK(nm, 1'b1, (cnt + 16'(tol) >= e) && (cnt <= e + 16'(tol)))
	endtask
	task automatic end_of_test;
		$display("errors=%0d samples_checked=%0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h3433110c));
		{resetn, brk, bce, wait_mode, ext_clk, ch1_in, ch0_in} = 7'b0000000;
		repeat (5) @(posedge clk_sys);
		resetn <= 1'b1;
		// Reset values and refused accesses
		r(A_SC);  `CHK("status", 8'h20, d)
		`CHK("ch1_preset", 1'b1, ch1_out)
		r(A_PH);  `CHK("period_hi", 8'hFF, d)
		rc;       `CHK("counter", 16'h0000, cnt)
		r(4'hF);  `CHK("unmapped", 8'h00, d)
		@(posedge clk_sys);
		wait_mode <= 1'b1;
		w(A_PL, 8'($urandom));
		r(A_PH);  `CHK("wait_read", 8'h00, d)
		@(posedge clk_sys);
		wait_mode <= 1'b0;
		r(A_PL);  `CHK("wait_refused", 8'hFF, d)
		// Every internal divider
		for (i = 0; i < 7; i++) begin
			w(A_SC, 8'h30);
			w(A_SC, 8'(i));
			repeat (128) @(posedge clk_sys);
			w(A_SC, 8'h20 | 8'(i));
			rc;
			near("prescaled", presc_exp(130, i), 3);
		end
		// External clock pulses
		n = 5 + $urandom_range(15);
		w(A_SC, 8'h30);
		w(A_SC, 8'h07);
		repeat (2) @(posedge clk_sys);
		`CHK("force_in", 1'b1, force_in)
		repeat (n) begin
			@(posedge clk_sys);
			ext_clk <= 1'b1;
			repeat (2) @(posedge clk_sys);
			ext_clk <= 1'b0;
			@(posedge clk_sys);
		end
		repeat (4) @(posedge clk_sys);
		w(A_SC, 8'h27);
		rc;
		near("ext_count", 16'(n), 0);
		// Halt with reset, then latched low byte
		w(A_SC, 8'h30);
		rc;       `CHK("halt_reset", 16'h0000, cnt)
		w(A_SC, 8'h00);
		repeat (100) @(posedge clk_sys);
		w(A_SC, 8'h20);
		rc;
		exp16 = cnt;
		w(A_SC, 8'h00);
		r(A_CH);
		repeat (40) @(posedge clk_sys);
		r(A_CL);
		cnt = {8'h00, d};
		near("latched_low", {8'h00, exp16[7:0] + 8'h02}, 2);
		// Overflow, flag clearing and break
		n = 8 + $urandom_range(24);
		w(A_SC, 8'h30);
		w(A_PH, 8'h00);
		w(A_PL, 8'(n));
		w(A_SC, 8'h00);
		repeat (n + 6) @(posedge clk_sys);
		w(A_SC, 8'h20);
		r(A_SC);  `CHK("ovf_set", 8'hA0, d)
		rc;       `CHK("wrapped", 1'b1, cnt <= 16'(n))
		`CHK("irq_masked", 1'b0, ovf_irq)
		w(A_SC, 8'hE0);
		repeat (2) @(posedge clk_sys);
		`CHK("ovf_irq", 1'b1, ovf_irq)
		`CHK("wake", 1'b1, wake)
		r(A_SC);  `CHK("one_write", 8'hE0, d)
		@(posedge clk_sys);
		brk <= 1'b1;
		w(A_SC, 8'h40);
		r(A_SC);  `CHK("break_kept", 8'hC0, d)
		rc;
		exp16 = cnt;
		repeat (30) @(posedge clk_sys);
		rc;       `CHK("break_stop", exp16, cnt)
		w(A_SC, 8'h60);
		@(posedge clk_sys);
		brk <= 1'b0;
		w(A_SC, 8'h60);
		r(A_SC);  `CHK("ovf_cleared", 8'h60, d)
		`CHK("ovf_irq_low", 1'b0, ovf_irq)
		// Channel 1 capture and flag clear
		w(ADDR_CH1_CONTROL, 8'h44);
		@(posedge clk_sys);
		ch1_in <= 1'b1;
		repeat (4) @(posedge clk_sys);
		`CHK("ch1_irq", 1'b1, ch1_irq)
		r(ADDR_CH1_CONTROL);
		w(ADDR_CH1_CONTROL, 8'h44);
		repeat (2) @(posedge clk_sys);
		`CHK("ch1_cleared", 1'b0, ch1_irq)
		`CHK("ch1_drive", 1'b0, ch1_oe)
		// Channel 0 falling-edge capture of the halted counter
		ch0_in <= 1'b1;
		w(ADDR_CH0_CONTROL, 8'h48);
		repeat (3) @(posedge clk_sys);
		ch0_in <= 1'b0;
		repeat (3) @(posedge clk_sys);
		`CHK("ch0_irq", 1'b1, ch0_irq)
		rc;
		r(ADDR_CH0_HIGH);
		exp16[15:8] = d;
		r(ADDR_CH0_LOW);
		exp16[7:0] = d;
		`CHK("ch0_capture", cnt, exp16)
		// Channel 0 duty modes, plain PWM and overflow beating compare
		for (i = 0; i < 5; i++) begin
			w(A_SC, 8'h30);
			w(A_PH, 8'h00);
			w(A_PL, 8'h0F);
			w(ADDR_CH0_HIGH, 8'h00);
			w(ADDR_CH0_LOW, cmp[i]);
			w(ADDR_CH0_CONTROL, ctl[i]);
			w(A_SC, 8'h00);
			repeat (48) @(posedge clk_sys);
			n = 0;
			for (j = 0; j < 64; j++) begin
				@(negedge clk_sys);
				n += (ch0_out === 1'b1) ? 1 : 0;
				if (hi[i] == 0 || hi[i] == 64)
					`CHK("pwm_level", hi[i] == 64, ch0_out)
			end
			`CHK("pwm_high", hi[i], n)
			`CHK("ch0_drive", 1'b1, ch0_oe)
			`CHK("ch1_released", 1'b0, ch1_oe)
			`CHK("ch0_irq_masked", 1'b0, ch0_irq)
			r(ADDR_CH0_CONTROL);
			`CHK("ch0_flag", 1'b1, d[7])
		end
		// Mid-run reset clears flags and reloads the period limit
		resetn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		resetn <= 1'b1;
		r(A_SC);  `CHK("status_reset", 8'h20, d)
		r(A_PL);  `CHK("period_lo_reset", 8'hFF, d)
		r(ADDR_CH0_CONTROL);
		`CHK("ch0_reset", 8'h00, d)
		end_of_test();
	end
endmodule

// File: timer_core.sv
// Sixteen-bit timer core: prescaler or external clock, modulo counter,
// overflow flag, two capture/compare/PWM channels and a byte register port.
// Assumes all inputs synchronous to clk_sys; break and wait come from the
// system controller; channel pins are resolved by the port logic outside.
//
// Function
// - Channel 0 buffered select links both channels
// - Overflow toggle off with clear on compare gives constant 0% output
// - Full duty plus overflow toggle gives 100%
// - Overflow flag with enable raises interrupt request
// - Channel events set flag; interrupt when enabled
// - Wait keeps counting, blocks registers, wakes controller
// - Break holds the counter stopped
// - Break protects flags unless clear enable set
// - Prescale select picks divider or external clock
// - External clock selected forces pin as input
// - Overflow flag clears by read then 0-write
// - Halt set by reset, holds counter value
// - Counter reset bit clears counter and prescaler
// - Halt with counter reset stops at zero
// - High byte read latches low byte
// - Match with period limit wraps, sets flag
// - Period high write inhibits overflow flag until low
// - Reset loads period limit with all ones
// - Channels independent unless channel 0 buffered; only channel 0 buffers
// - Channel flag clears by read then 0-write
// - Overflow toggle beats simultaneous compare
// - Full duty change acts next period
// - Channel high write inhibits compare until low
`timescale 1ns/1ps

module timer_core
	import timer_pkg::*;
(
	input  wire logic       clk_sys,
	input  wire logic       resetn,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_stb,
	input  wire logic       rd_stb,
	output logic      [7:0] rdata,
	input  wire logic       break_active,
	input  wire logic       break_clear_enable,
	input  wire logic       wait_mode,
	input  wire logic       external_timer_clock_pin,
	output logic            external_clock_force_input,
	input  wire logic       channel0_pin_in,
	output logic            channel0_pin_out,
	output logic            channel0_pin_oe,
	input  wire logic       channel1_pin_in,
	output logic            channel1_pin_out,
	output logic            channel1_pin_oe,
	output logic            overflow_irq,
	output logic            channel0_irq,
	output logic            channel1_irq,
	output logic            wake_request
);

	// ==========================================================
	// State
	typedef struct packed {
		logic [15:0]      counter;
		logic [5:0]       prescale;
		logic [7:0]       latch_low;
		logic             latched;
		logic [15:0]      period;
		logic             period_inhibit;
		logic             ovf_flag;
		logic             ovf_arm;
		logic             ovf_ie;
		logic             halt;
		logic [2:0]       ps;
		logic             ext_prev;
		logic [1:0][7:0]  ch_ctl;
		logic [1:0]       ch_flag;
		logic [1:0]       ch_arm;
		logic [1:0][15:0] ch_val;
		logic [1:0]       cmp_inhibit;
		logic [1:0]       cap_inhibit;
		logic [1:0]       out_lvl;
		logic [1:0]       max_eff;
		logic [1:0]       pin_prev;
		logic             buf_active;
		logic             buf_pending;
		logic [7:0]       rdata;
		logic [1:0]       pin_out;
		logic [1:0]       pin_oe;
		logic             ext_force;
		logic             ovf_irq;
		logic [1:0]       ch_irq;
		logic             wake;
	} state_t;

	state_t state_reg;
	state_t state_next;

	logic       tick;
	logic       ovf_hit;
	logic [1:0] cmp_hit;

	// ==========================================================
	// Helpers
	// Mask of prescaler bits that must all be one for a tick
	function automatic logic [5:0] ps_mask(input logic [2:0] ps);
		logic [5:0] m;
		m = PRESCALE_ZERO;
		for (int k = 0; k < 6; k++) begin
			if (k < int'(ps))
				m[k] = 1'b1;
		end
		return m;
	endfunction

	// Output level after a compare action
	function automatic logic edge_action(input logic [1:0] els, input logic lvl);
		logic res;
		res = lvl;
		case (els)
			ELS_TOGGLE: res = ~lvl;
			ELS_CLEAR:  res = 1'b0;
			ELS_SET:    res = 1'b1;
			default:    res = lvl;
		endcase
		return res;
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		logic       acc_rd;
		logic       acc_wr;
		logic       flag_ops;
		logic       ext_rise;
		logic       run;
		logic       linked;
		logic       mode_cmp;
		logic       mode_cap;
		logic [1:0] els;
		logic [15:0] cval;
		logic       edge_seen;
		logic [1:0] ch_ev;
		logic [7:0] rd_val;
		state_next = state_reg;
		acc_rd     = rd_stb & ~wait_mode;
		acc_wr     = wr_stb & ~wait_mode;
		flag_ops   = ~(break_active & ~break_clear_enable);
		ext_rise   = external_timer_clock_pin & ~state_reg.ext_prev;
		run        = ~state_reg.halt & ~break_active;
		linked     = state_reg.ch_ctl[0][CH_MSB];
		mode_cmp   = 1'b0;
		mode_cap   = 1'b0;
		els        = ELS_NONE;
		cval       = COUNTER_ZERO;
		edge_seen  = 1'b0;
		ch_ev      = 2'b00;
		rd_val     = BYTE_ZERO;
		cmp_hit    = 2'b00;
		state_next.ext_prev = external_timer_clock_pin;

		// Prescaler and counter advance
		if (state_reg.ps == PS_EXTERNAL)
			tick = run & ext_rise;
		else
			tick = run & ((state_reg.prescale & ps_mask(state_reg.ps)) ==
				ps_mask(state_reg.ps));
		if (run)
			state_next.prescale = state_reg.prescale + PRESCALE_ONE;
		ovf_hit = tick & (state_reg.counter == state_reg.period);
		if (ovf_hit)
			state_next.counter = COUNTER_ZERO;
		else if (tick)
			state_next.counter = state_reg.counter + COUNTER_ONE;
		if (ovf_hit & linked)
			state_next.buf_active = state_reg.buf_pending;

		// Channels
		for (int i = 0; i < 2; i++) begin
			els = state_reg.ch_ctl[i][CH_ELSB:CH_ELSA];
			if (i == 0) begin
				mode_cmp = state_reg.ch_ctl[0][CH_MSB] | state_reg.ch_ctl[0][CH_MSA];
				mode_cap = ~mode_cmp & (els != ELS_NONE);
				cval = (linked & state_reg.buf_active) ? state_reg.ch_val[1] :
					state_reg.ch_val[0];
			end else begin
				mode_cmp = state_reg.ch_ctl[1][CH_MSA] & ~linked;
				mode_cap = ~state_reg.ch_ctl[1][CH_MSA] & ~linked & (els != ELS_NONE);
				cval = state_reg.ch_val[1];
			end
			cmp_hit[i] = tick & mode_cmp & ~state_reg.cmp_inhibit[i] &
				(state_reg.counter == cval);
			case (els)
				ELS_TOGGLE: edge_seen = state_reg.pin_prev[i] != (i == 0 ?
					channel0_pin_in : channel1_pin_in) ? ~state_reg.pin_prev[i] : 1'b0;
				ELS_CLEAR:  edge_seen = state_reg.pin_prev[i] & ~(i == 0 ?
					channel0_pin_in : channel1_pin_in);
				ELS_SET:    edge_seen = state_reg.pin_prev[i] ^ (i == 0 ?
					channel0_pin_in : channel1_pin_in);
				default:    edge_seen = 1'b0;
			endcase
			if (mode_cap & edge_seen & ~state_reg.cap_inhibit[i])
				state_next.ch_val[i] = state_reg.counter;
			ch_ev[i] = cmp_hit[i] | (mode_cap & edge_seen);
			state_next.pin_prev[i] = (i == 0) ? channel0_pin_in : channel1_pin_in;
			// Output level: preset, overflow toggle first, then compare
			if (els == ELS_NONE)
				state_next.out_lvl[i] = ~state_reg.ch_ctl[i][CH_MSA];
			else if (mode_cmp & ovf_hit & state_reg.ch_ctl[i][CH_TOV])
				state_next.out_lvl[i] = ~state_reg.out_lvl[i];
			else if (cmp_hit[i])
				state_next.out_lvl[i] = edge_action(els, state_reg.out_lvl[i]);
			if (ovf_hit)
				state_next.max_eff[i] = state_reg.ch_ctl[i][CH_MAX];
		end

		// Register writes
		if (acc_wr) begin
			case (addr)
				ADDR_STATUS_CONTROL: begin
					if (flag_ops & state_reg.ovf_arm & ~wdata[SC_OVF_FLAG]) begin
						state_next.ovf_flag = 1'b0;
						state_next.ovf_arm  = 1'b0;
					end
					state_next.ovf_ie = wdata[SC_OVF_IE];
					state_next.halt   = wdata[SC_HALT];
					state_next.ps     = wdata[SC_PS_MSB:SC_PS_LSB];
					if (wdata[SC_CNT_RESET]) begin
						state_next.counter  = COUNTER_ZERO;
						state_next.prescale = PRESCALE_ZERO;
						state_next.latched  = 1'b0;
					end
				end
				ADDR_PERIOD_HIGH: begin
					state_next.period[15:8]   = wdata;
					state_next.period_inhibit = 1'b1;
				end
				ADDR_PERIOD_LOW: begin
					state_next.period[7:0]    = wdata;
					state_next.period_inhibit = 1'b0;
				end
				ADDR_CH0_CONTROL, ADDR_CH1_CONTROL: begin
					for (int i = 0; i < 2; i++) begin
						if (addr == (i == 0 ? ADDR_CH0_CONTROL : ADDR_CH1_CONTROL)) begin
							if (flag_ops & state_reg.ch_arm[i] & ~wdata[CH_FLAG]) begin
								state_next.ch_flag[i] = 1'b0;
								state_next.ch_arm[i]  = 1'b0;
							end
							state_next.ch_ctl[i] = {1'b0, wdata[6:0]};
							if (i == 1)
								state_next.ch_ctl[1][CH_MSB] = 1'b0;
						end
					end
				end
				ADDR_CH0_HIGH: begin
					state_next.ch_val[0][15:8] = wdata;
					state_next.cmp_inhibit[0]  = 1'b1;
				end
				ADDR_CH0_LOW: begin
					state_next.ch_val[0][7:0]  = wdata;
					state_next.cmp_inhibit[0]  = 1'b0;
					state_next.buf_pending     = 1'b0;
				end
				ADDR_CH1_HIGH: begin
					state_next.ch_val[1][15:8] = wdata;
					state_next.cmp_inhibit[1]  = 1'b1;
				end
				ADDR_CH1_LOW: begin
					state_next.ch_val[1][7:0]  = wdata;
					state_next.cmp_inhibit[1]  = 1'b0;
					state_next.buf_pending     = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// Register reads and their side effects
		if (acc_rd) begin
			case (addr)
				ADDR_STATUS_CONTROL: begin
					rd_val = {state_reg.ovf_flag, state_reg.ovf_ie, state_reg.halt,
						1'b0, 1'b0, state_reg.ps};
					if (flag_ops & state_reg.ovf_flag)
						state_next.ovf_arm = 1'b1;
				end
				ADDR_COUNTER_HIGH: begin
					rd_val = state_reg.counter[15:8];
					if (~state_reg.latched) begin
						state_next.latched   = 1'b1;
						state_next.latch_low = state_reg.counter[7:0];
					end
				end
				ADDR_COUNTER_LOW: begin
					rd_val = state_reg.latched ? state_reg.latch_low :
						state_reg.counter[7:0];
					state_next.latched = 1'b0;
				end
				ADDR_PERIOD_HIGH: rd_val = state_reg.period[15:8];
				ADDR_PERIOD_LOW:  rd_val = state_reg.period[7:0];
				ADDR_CH0_CONTROL: begin
					rd_val = state_reg.ch_ctl[0] | {state_reg.ch_flag[0], 7'h00};
					if (flag_ops & state_reg.ch_flag[0])
						state_next.ch_arm[0] = 1'b1;
				end
				ADDR_CH1_CONTROL: begin
					rd_val = state_reg.ch_ctl[1] | {state_reg.ch_flag[1], 7'h00};
					if (flag_ops & state_reg.ch_flag[1])
						state_next.ch_arm[1] = 1'b1;
				end
				ADDR_CH0_HIGH: begin
					rd_val = state_reg.ch_val[0][15:8];
					state_next.cap_inhibit[0] = 1'b1;
				end
				ADDR_CH0_LOW: begin
					rd_val = state_reg.ch_val[0][7:0];
					state_next.cap_inhibit[0] = 1'b0;
				end
				ADDR_CH1_HIGH: begin
					rd_val = state_reg.ch_val[1][15:8];
					state_next.cap_inhibit[1] = 1'b1;
				end
				ADDR_CH1_LOW: begin
					rd_val = state_reg.ch_val[1][7:0];
					state_next.cap_inhibit[1] = 1'b0;
				end
				default: rd_val = BYTE_ZERO;
			endcase
		end
		state_next.rdata = rd_val;

		// Events set flags; a set wins over a clear in the same cycle
		if (ovf_hit & ~state_next.period_inhibit & ~state_reg.period_inhibit) begin
			state_next.ovf_flag = 1'b1;
			state_next.ovf_arm  = 1'b0;
		end
		for (int i = 0; i < 2; i++) begin
			if (ch_ev[i]) begin
				state_next.ch_flag[i] = 1'b1;
				state_next.ch_arm[i]  = 1'b0;
			end
		end

		// Pin drive and interrupt levels
		state_next.pin_oe[0]  = (state_next.ch_ctl[0][CH_MSB] |
			state_next.ch_ctl[0][CH_MSA]) &
			(state_next.ch_ctl[0][CH_ELSB:CH_ELSA] != ELS_NONE);
		state_next.pin_oe[1]  = state_next.ch_ctl[1][CH_MSA] & ~state_next.ch_ctl[0][CH_MSB] &
			(state_next.ch_ctl[1][CH_ELSB:CH_ELSA] != ELS_NONE);
		for (int i = 0; i < 2; i++) begin
			state_next.pin_out[i] = (state_next.ch_ctl[i][CH_TOV] & state_next.max_eff[i]) |
				state_next.out_lvl[i];
			state_next.ch_irq[i] = state_next.ch_flag[i] & state_next.ch_ctl[i][CH_IE];
		end
		state_next.ext_force = (state_next.ps == PS_EXTERNAL);
		state_next.ovf_irq   = state_next.ovf_flag & state_next.ovf_ie;
		state_next.wake      = state_next.ovf_irq | (|state_next.ch_irq);
	end

	// ==========================================================
	// State register
	always_ff @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			state_reg        <= '0;
			state_reg.halt   <= 1'b1;
			state_reg.period <= PERIOD_RESET;
			state_reg.out_lvl <= 2'b11;
			state_reg.pin_out <= 2'b11;
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flops
	assign rdata                      = state_reg.rdata;
	assign external_clock_force_input = state_reg.ext_force;
	assign channel0_pin_out           = state_reg.pin_out[0];
	assign channel0_pin_oe            = state_reg.pin_oe[0];
	assign channel1_pin_out           = state_reg.pin_out[1];
	assign channel1_pin_oe            = state_reg.pin_oe[1];
	assign overflow_irq               = state_reg.ovf_irq;
	assign channel0_irq               = state_reg.ch_irq[0];
	assign channel1_irq               = state_reg.ch_irq[1];
	assign wake_request               = state_reg.wake;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	sequence seq_ovf_event;
		ovf_hit && !state_reg.period_inhibit && !(wr_stb && addr == ADDR_PERIOD_HIGH);
	endsequence
	sequence seq_flag_clear_write;
		wr_stb && !wait_mode && addr == ADDR_STATUS_CONTROL && !wdata[SC_OVF_FLAG];
	endsequence

	AST_SET_WINS: assert property (seq_ovf_event ##0 seq_flag_clear_write |=> state_reg.ovf_flag)
		else $error("overflow lost to a clear");
	AST_HALT_HOLDS: assert property (state_reg.halt && !wr_stb |=> $stable(state_reg.counter))
		else $error("counter moved while halted");
	AST_BREAK_HOLDS: assert property (break_active && !wr_stb |=> $stable(state_reg.counter))
		else $error("counter moved in break");
	AST_WRAP: assert property (ovf_hit && !wr_stb |=> state_reg.counter == COUNTER_ZERO)
		else $error("counter did not wrap");
	AST_CNT_RESET: assert property (wr_stb && !wait_mode && addr == ADDR_STATUS_CONTROL &&
		wdata[SC_CNT_RESET] |=> state_reg.counter == COUNTER_ZERO && !state_reg.latched)
		else $error("counter reset failed");
	AST_LATCH: assert property (rd_stb && !wait_mode && addr == ADDR_COUNTER_HIGH &&
		!state_reg.latched && !wr_stb |=> state_reg.latched &&
		state_reg.latch_low == $past(state_reg.counter[7:0]))
		else $error("low byte not latched");
	AST_INHIBIT: assert property (state_reg.period_inhibit && !wr_stb |=>
		!$rose(state_reg.ovf_flag))
		else $error("overflow flagged while inhibited");
	AST_IRQ_LEVEL: assert property (overflow_irq == (state_reg.ovf_flag && state_reg.ovf_ie) &&
		channel0_irq == (state_reg.ch_flag[0] && state_reg.ch_ctl[0][CH_IE]))
		else $error("interrupt level mismatch");
	AST_FULL_DUTY: assert property (state_reg.ch_ctl[0][CH_TOV] && state_reg.max_eff[0] |->
		channel0_pin_out)
		else $error("full duty output low");
	AST_ZERO_DUTY: assert property (!state_reg.ch_ctl[0][CH_TOV] && !channel0_pin_out &&
		state_reg.ch_ctl[0][CH_ELSB:CH_ELSA] == ELS_CLEAR && !wr_stb |=> !channel0_pin_out)
		else $error("zero duty output rose");
	AST_WAKE: assert property (overflow_irq |-> wake_request)
		else $error("no wake on interrupt");

endmodule

// File: timer_pkg.sv
// Constants for the sixteen-bit timer core: register map, field positions,
// reset values and clock figures.
// Assumes a byte-wide register port and a single 20 MHz system clock.
package timer_pkg;

	// ==========================================================
	// Register map, one byte per address
	localparam logic [3:0] ADDR_STATUS_CONTROL = 4'h0;
	localparam logic [3:0] ADDR_COUNTER_HIGH   = 4'h1;
	localparam logic [3:0] ADDR_COUNTER_LOW    = 4'h2;
	localparam logic [3:0] ADDR_PERIOD_HIGH    = 4'h3;
	localparam logic [3:0] ADDR_PERIOD_LOW     = 4'h4;
	localparam logic [3:0] ADDR_CH0_CONTROL    = 4'h5;
	localparam logic [3:0] ADDR_CH0_HIGH       = 4'h6;
	localparam logic [3:0] ADDR_CH0_LOW        = 4'h7;
	localparam logic [3:0] ADDR_CH1_CONTROL    = 4'h8;
	localparam logic [3:0] ADDR_CH1_HIGH       = 4'h9;
	localparam logic [3:0] ADDR_CH1_LOW        = 4'hA;

	// ==========================================================
	// Timer status/control fields
	localparam int SC_OVF_FLAG  = 7;
	localparam int SC_OVF_IE    = 6;
	localparam int SC_HALT      = 5;
	localparam int SC_CNT_RESET = 4;
	localparam int SC_PS_MSB    = 2;
	localparam int SC_PS_LSB    = 0;

	// ==========================================================
	// Channel status/control fields
	localparam int CH_FLAG = 7;
	localparam int CH_IE   = 6;
	localparam int CH_MSB  = 5;
	localparam int CH_MSA  = 4;
	localparam int CH_ELSB = 3;
	localparam int CH_ELSA = 2;
	localparam int CH_TOV  = 1;
	localparam int CH_MAX  = 0;

	// ==========================================================
	// Encodings and reset values
	localparam logic [2:0]  PS_EXTERNAL    = 3'h7;
	localparam logic [1:0]  ELS_NONE       = 2'h0;
	localparam logic [1:0]  ELS_TOGGLE     = 2'h1;
	localparam logic [1:0]  ELS_CLEAR      = 2'h2;
	localparam logic [1:0]  ELS_SET        = 2'h3;
	localparam logic [15:0] COUNTER_ZERO   = 16'h0000;
	localparam logic [15:0] PERIOD_RESET   = 16'hFFFF;
	localparam logic [7:0]  BYTE_ZERO      = 8'h00;
	localparam logic [5:0]  PRESCALE_ZERO  = 6'h00;
	localparam logic [5:0]  PRESCALE_ONE   = 6'h01;
	localparam logic [15:0] COUNTER_ONE    = 16'h0001;
	localparam int          CLK_PERIOD_NS  = 50;

endpackage
